//--- logic/tsfd_key_decode.sv
// Key decoder for the wheel, paired-press and row/column matrix layouts.
`timescale 1ns/1ps
module tsfd_key_decode
  import tsfd_pkg::*;
(
  // Layout selection
  input wire tsfd_mode_t mode,
  // Per-channel shift, trip level and debounced press state
  input wire logic [DEC_CH-1:0][RAW_W-1:0] shift,
  input wire logic [DEC_CH-1:0][RAW_W-1:0] trip,
  input wire logic [DEC_CH-1:0] pressed,
  // Decoded key, zero when none
  output logic [KEY_W-1:0] key
);
  logic [DEC_CH-1:0] quarter;
  logic [DEC_CH-1:0] half;

  // Quarter band is trip/8 either side of trip/4; half band runs from 3/8 to 3/4 of trip.
  genvar g;
  generate
    for (g = 0; g < DEC_CH; g++) begin : g_band
      logic [RAW_W-1:0] t8;
      assign t8 = trip[g] >> 3;
      assign quarter[g] = (shift[g] >= t8) &&
                          (shift[g] < (trip[g] >> 2) + t8);
      assign half[g] = (shift[g] >= (trip[g] >> 2) + t8) &&
                       (shift[g] < (trip[g] >> 1) + (trip[g] >> 2));
    end
  endgenerate

  always_comb begin
    logic found;
    logic [KEY_W-1:0] code;
    logic [RAW_W-1:0] best_r;
    logic [RAW_W-1:0] best_c;
    int unsigned row;
    int unsigned col;
    logic row_ok;
    logic col_ok;
    found = 1'b0;
    code = KEY_PAIR_BASE;
    best_r = '0;
    best_c = '0;
    row = 0;
    col = 0;
    row_ok = 1'b0;
    col_ok = 1'b0;
    key = KEY_NONE;
    unique case (mode)
      TSFD_MODE_WHEEL: begin
        if (&quarter[WHEEL_CH-1:0]) begin
          key = KEY_CENTRE;
          found = 1'b1;
        end
        for (int i = 0; i < WHEEL_CH; i++) begin
          if (!found && half[i] && half[(i + 1) % WHEEL_CH]) begin
            key = KEY_DIAG_BASE + KEY_W'(i);
            found = 1'b1;
          end
        end
        for (int i = 0; i < WHEEL_CH; i++) begin
          if (!found && pressed[i]) begin
            key = KEY_SINGLE_BASE + KEY_W'(i);
            found = 1'b1;
          end
        end
      end
      TSFD_MODE_PAIRED: begin
        for (int i = 0; i < WHEEL_CH; i++) begin
          for (int j = i + 1; j < WHEEL_CH; j++) begin
            if (!found && half[i] && half[j]) begin
              key = code;
              found = 1'b1;
            end
            code = code + KEY_W'(1);
          end
        end
        for (int i = 0; i < WHEEL_CH; i++) begin
          if (!found && pressed[i]) begin
            key = KEY_SINGLE_BASE + KEY_W'(i);
            found = 1'b1;
          end
        end
      end
      TSFD_MODE_MATRIX: begin
        // Coupling can trip neighbours, so only the deepest line counts.
        for (int i = 0; i < MTX_ROWS; i++) begin
          if (pressed[i] && (!row_ok || shift[i] > best_r)) begin
            best_r = shift[i];
            row = i;
            row_ok = 1'b1;
          end
        end
        for (int i = 0; i < MTX_COLS; i++) begin
          if (pressed[MTX_ROWS+i] &&
              (!col_ok || shift[MTX_ROWS+i] > best_c)) begin
            best_c = shift[MTX_ROWS+i];
            col = i;
            col_ok = 1'b1;
          end
        end
        if (row_ok && col_ok) begin
          key = KEY_W'(row * MTX_COLS + col + 1);
        end
      end
      default: key = KEY_NONE;
    endcase
  end
endmodule // tsfd_key_decode

//--- logic/tsfd_pkg.sv
// Shared constants and types for the touch sensor filter and decoder.
package tsfd_pkg;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned SLOT_PERIOD_NS = 1_000_000;
  localparam int unsigned SLOT_CYCLES = SLOT_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned CONV_TIME_NS = 12_000;
  localparam int unsigned NUM_CH = 16;
  localparam int unsigned CH_W = 4;
  localparam int unsigned RAW_W = 10;
  localparam int unsigned TRIM_W = 8;
  localparam int unsigned OVS_READS = 64;
  localparam int unsigned OVS_SHIFT = 6;
  localparam int unsigned OVS_CNT_W = 6;
  localparam int unsigned ACC_W = RAW_W + OVS_SHIFT;
  localparam int unsigned HIST_DEPTH = 4;
  localparam int unsigned HIST_SHIFT = 2;
  localparam int unsigned HIST_IDX_W = 2;
  localparam int unsigned HSUM_W = RAW_W + HIST_SHIFT;
  localparam int unsigned BASE_SHIFT = 2;
  localparam int unsigned BASE_EVERY_W = 4;
  localparam int unsigned DBNC_W = 3;
  localparam logic [DBNC_W-1:0] DBNC_DEFAULT = 3'h3;
  localparam int unsigned DEC_CH = 9;
  localparam int unsigned MTX_ROWS = 4;
  localparam int unsigned MTX_COLS = 5;
  localparam int unsigned WHEEL_CH = 4;
  localparam int unsigned KEY_W = 5;
  localparam logic [KEY_W-1:0] KEY_NONE = 5'h00;
  localparam logic [KEY_W-1:0] KEY_SINGLE_BASE = 5'h01;
  localparam logic [KEY_W-1:0] KEY_DIAG_BASE = 5'h05;
  localparam logic [KEY_W-1:0] KEY_PAIR_BASE = 5'h05;
  localparam logic [KEY_W-1:0] KEY_CENTRE = 5'h09;

  typedef enum logic [1:0] {
    TSFD_MODE_WHEEL = 2'h0,
    TSFD_MODE_PAIRED = 2'h1,
    TSFD_MODE_MATRIX = 2'h2
  } tsfd_mode_t;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_TRIM = 6'h02,
    S_CONV = 6'h04,
    S_WAIT = 6'h08,
    S_AVG = 6'h10,
    S_EVAL = 6'h20
  } tsfd_state_t;
endpackage

//--- logic/tsfd_top.sv
// Oversampling, filtering, debouncing and key decoding of touch readings.
`timescale 1ns/1ps
module tsfd_top
  import tsfd_pkg::*;
#(
  parameter int unsigned SLOT_CNT = SLOT_CYCLES
)(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Configuration
  input wire tsfd_mode_t mode,
  input wire logic [DBNC_W-1:0] dbnc_count,
  input wire logic cfg_wr,
  input wire logic [CH_W-1:0] cfg_chan,
  input wire logic [TRIM_W-1:0] cfg_trim,
  input wire logic [RAW_W-1:0] cfg_trip,
  // Charge measurement front end
  output logic [CH_W-1:0] chan_sel,
  output logic [TRIM_W-1:0] current_trim_control,
  output logic conv_start,
  input wire logic conv_valid,
  input wire logic [RAW_W-1:0] conv_data,
  // Results
  output logic [NUM_CH-1:0] sensor_pressed,
  output logic [KEY_W-1:0] key_code,
  output logic key_event
);
  tsfd_state_t state_q;
  logic [$clog2(SLOT_CNT)-1:0] slot_cnt_q;
  logic slot_tick;
  logic [CH_W-1:0] chan_q;
  logic [OVS_CNT_W-1:0] rd_cnt_q;
  logic [ACC_W-1:0] acc_q;
  logic [RAW_W-1:0] ovs_q;
  logic [TRIM_W-1:0] trim_q;
  logic [TRIM_W-1:0] trim_tab [NUM_CH];
  logic [RAW_W-1:0] trip_tab [NUM_CH];
  logic [RAW_W-1:0] hist [NUM_CH][HIST_DEPTH];
  logic [HIST_IDX_W-1:0] hidx [NUM_CH];
  logic [HSUM_W-1:0] hsum [NUM_CH];
  logic [RAW_W-1:0] base [NUM_CH];
  logic [NUM_CH-1:0] seeded_q;
  logic [RAW_W-1:0] shift_q [NUM_CH];
  logic [DBNC_W-1:0] dcnt [NUM_CH];
  logic [BASE_EVERY_W-1:0] scan_q;
  logic [RAW_W-1:0] filt;
  logic [RAW_W-1:0] cur_base;
  logic [RAW_W-1:0] shift_now;
  logic raw_press;
  logic [DEC_CH-1:0][RAW_W-1:0] dec_shift;
  logic [DEC_CH-1:0][RAW_W-1:0] dec_trip;
  logic [KEY_W-1:0] dec_key;
  logic [KEY_W-1:0] key_q;
  logic key_ev_q;

  // Slot timer; the slot must cover all reads of roughly 12 us each.
  assign slot_tick = (slot_cnt_q == $bits(slot_cnt_q)'(SLOT_CNT - 1));
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      slot_cnt_q <= '0;
    end else if (slot_tick) begin
      slot_cnt_q <= '0;
    end else begin
      slot_cnt_q <= slot_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= S_IDLE;
    end else begin
      unique case (state_q)
        S_IDLE: if (slot_tick) state_q <= S_TRIM;
        S_TRIM: state_q <= S_CONV;
        S_CONV: state_q <= S_WAIT;
        S_WAIT: begin
          if (conv_valid) begin
            state_q <= (rd_cnt_q == OVS_CNT_W'(OVS_READS - 1)) ?
                       S_AVG : S_CONV;
          end
        end
        S_AVG: state_q <= S_EVAL;
        S_EVAL: state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trim_q <= '0;
    end else if (state_q == S_TRIM) begin
      trim_q <= trim_tab[chan_q];
    end
  end

  // Tables clear on reset, so the decoder never meets unknown trip levels.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int c = 0; c < NUM_CH; c++) begin
        trim_tab[c] <= '0;
        trip_tab[c] <= '0;
      end
    end else if (cfg_wr) begin
      trim_tab[cfg_chan] <= cfg_trim;
      trip_tab[cfg_chan] <= cfg_trip;
    end
  end

  // Sum of 64 ten-bit reads fits in sixteen bits, so no clamp is needed.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_q <= '0;
      rd_cnt_q <= '0;
      ovs_q <= '0;
    end else if (state_q == S_TRIM) begin
      acc_q <= '0;
      rd_cnt_q <= '0;
    end else if (state_q == S_WAIT && conv_valid) begin
      acc_q <= acc_q + ACC_W'(conv_data);
      rd_cnt_q <= rd_cnt_q + 1'b1;
      if (rd_cnt_q == OVS_CNT_W'(OVS_READS - 1)) begin
        ovs_q <= RAW_W'((acc_q + ACC_W'(conv_data)) >> OVS_SHIFT);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int c = 0; c < NUM_CH; c++) begin
        hidx[c] <= '0;
        hsum[c] <= '0;
        for (int k = 0; k < HIST_DEPTH; k++) hist[c][k] <= '0;
      end
    end else if (state_q == S_AVG) begin
      hist[chan_q][hidx[chan_q]] <= ovs_q;
      hsum[chan_q] <= hsum[chan_q] - HSUM_W'(hist[chan_q][hidx[chan_q]])
                      + HSUM_W'(ovs_q);
      hidx[chan_q] <= hidx[chan_q] + 1'b1;
    end
  end

  // Touch raises capacitance, which lowers the reading below baseline.
  assign filt = RAW_W'(hsum[chan_q] >> HIST_SHIFT);
  assign cur_base = base[chan_q];
  assign shift_now = (cur_base > filt) ? cur_base - filt : '0;
  assign raw_press = shift_now > trip_tab[chan_q];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seeded_q <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        base[c] <= '0;
        shift_q[c] <= '0;
      end
    end else if (state_q == S_EVAL) begin
      shift_q[chan_q] <= shift_now;
      if (!seeded_q[chan_q]) begin
        // Seed only once the history holds real reads, not reset zeros.
        if (hidx[chan_q] == '0) begin
          base[chan_q] <= filt;
          seeded_q[chan_q] <= 1'b1;
        end
      end else if (scan_q == '0 && !raw_press) begin
        // Slow tracking, only while untouched, so a press is not absorbed.
        if (filt > cur_base) begin
          base[chan_q] <= RAW_W'(cur_base +
                                 ((filt - cur_base) >> BASE_SHIFT));
        end else begin
          base[chan_q] <= RAW_W'(cur_base - (shift_now >> BASE_SHIFT));
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sensor_pressed <= '0;
      for (int c = 0; c < NUM_CH; c++) dcnt[c] <= '0;
    end else if (state_q == S_EVAL) begin
      if (raw_press == sensor_pressed[chan_q]) begin
        dcnt[chan_q] <= '0;
      end else if (dcnt[chan_q] + 1'b1 >= dbnc_count) begin
        sensor_pressed[chan_q] <= raw_press;
        dcnt[chan_q] <= '0;
      end else begin
        dcnt[chan_q] <= dcnt[chan_q] + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chan_q <= '0;
      scan_q <= '0;
    end else if (state_q == S_EVAL) begin
      chan_q <= chan_q + 1'b1;
      if (chan_q == CH_W'(NUM_CH - 1)) scan_q <= scan_q + 1'b1;
    end
  end

  generate
    for (genvar i = 0; i < DEC_CH; i++) begin : g_dec
      assign dec_shift[i] = shift_q[i];
      assign dec_trip[i] = trip_tab[i];
    end
  endgenerate

  tsfd_key_decode u_dec (
    .mode(mode),
    .shift(dec_shift),
    .trip(dec_trip),
    .pressed(sensor_pressed[DEC_CH-1:0]),
    .key(dec_key)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      key_q <= KEY_NONE;
      key_ev_q <= 1'b0;
    end else begin
      key_q <= dec_key;
      key_ev_q <= (dec_key != key_q);
    end
  end

  assign chan_sel = chan_q;
  assign current_trim_control = trim_q;
  assign conv_start = (state_q == S_CONV);
  assign key_code = key_q;
  assign key_event = key_ev_q;
endmodule // tsfd_top

//--- tb/tsfd_fe_model.sv
// Behavioural charge front end answering each conversion request.
`timescale 1ns/1ps
module tsfd_fe_model
  import tsfd_pkg::*;
#(
  parameter int unsigned LAT = 0
)(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Requests from the block
  input wire logic conv_start,
  input wire logic [CH_W-1:0] chan_sel,
  // Untouched or touched level of each channel
  input wire logic [NUM_CH-1:0][RAW_W-1:0] level,
  // Answer
  output logic conv_valid,
  output logic [RAW_W-1:0] conv_data
);
  logic [3:0] wait_q;
  logic dith_q;
  logic fire;
  assign fire = conv_start ? (LAT == 0) : (wait_q == 4'h1);
  // Reads alternate above and below the level, so only a true mean of
  // all reads recovers it; between answers the data line keeps toggling.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_q <= 4'h0;
      dith_q <= 1'b0;
      conv_valid <= 1'b0;
      conv_data <= 10'h155;
    end else begin
      conv_valid <= fire;
      if (conv_start) begin
        wait_q <= LAT[3:0];
      end else if (wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end
      if (fire) begin
        conv_data <= dith_q ? level[chan_sel] + 10'h010
                            : level[chan_sel] - 10'h010;
        dith_q <= ~dith_q;
      end else begin
        conv_data <= ~conv_data;
      end
    end
  end
endmodule // tsfd_fe_model

//--- tb/tsfd_top_assertions.sv
// Port-level checks for the touch filter and key decoder.
`timescale 1ns/1ps
module tsfd_top_assertions
  import tsfd_pkg::*;
(
  // Clock, reset and configuration
  input wire logic clk,
  input wire logic arst_n,
  input wire tsfd_mode_t mode,
  input wire logic cfg_wr,
  input wire logic [CH_W-1:0] cfg_chan,
  input wire logic [TRIM_W-1:0] cfg_trim,
  // Front end
  input wire logic [CH_W-1:0] chan_sel,
  input wire logic [TRIM_W-1:0] current_trim_control,
  input wire logic conv_start,
  input wire logic conv_valid,
  // Results
  input wire logic [NUM_CH-1:0] sensor_pressed,
  input wire logic [KEY_W-1:0] key_code,
  input wire logic key_event
);
  logic [TRIM_W-1:0] trim_tab [NUM_CH];
  logic [6:0] starts_q;
  logic pend_q;
  always_ff @(posedge clk) begin
    if (cfg_wr) begin
      trim_tab[cfg_chan] <= cfg_trim;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      starts_q <= 7'h00;
      pend_q <= 1'b0;
    end else begin
      starts_q <= $changed(chan_sel) ? 7'h00 : starts_q + {6'h00, conv_start};
      pend_q <= conv_start | (pend_q & ~conv_valid);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_trim_loaded: assert property (
    conv_start |-> current_trim_control == trim_tab[chan_sel])
    else $error("trim differs from table");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("request longer than one cycle");
  a_no_overlap: assert property (pend_q |-> !conv_start)
    else $error("request while conversion pending");
  a_read_count: assert property (
    $changed(chan_sel) |-> starts_q == 7'h40)
    else $error("wrong read count in slot");
  a_chan_order: assert property (
    $changed(chan_sel) |-> chan_sel == $past(chan_sel) + 4'h1)
    else $error("channel order broken");
  a_event_follows: assert property (
    key_event == (key_code != $past(key_code)))
    else $error("key event not after key change");
  a_wheel_codes: assert property (
    (mode == TSFD_MODE_WHEEL && $past(mode) == TSFD_MODE_WHEEL)
    |-> key_code <= KEY_CENTRE) else $error("wheel code out of range");
  a_paired_codes: assert property (
    (mode == TSFD_MODE_PAIRED && $past(mode) == TSFD_MODE_PAIRED)
    |-> key_code <= 5'h0a) else $error("paired code out of range");
  a_matrix_needs: assert property (
    (mode == TSFD_MODE_MATRIX && $past(mode) == TSFD_MODE_MATRIX &&
     key_code != KEY_NONE) |-> ($past(sensor_pressed[3:0]) != 4'h0 &&
     $past(sensor_pressed[8:4]) != 5'h00) && key_code <= 5'h14)
    else $error("matrix key without row and column");
  a_press_single: assert property (
    $changed(sensor_pressed) |->
    $onehot(sensor_pressed ^ $past(sensor_pressed)))
    else $error("several press states changed at once");
  c_centre: cover property (key_code == KEY_CENTRE);
  c_pressed: cover property (sensor_pressed != 16'h0000);
  c_event: cover property (key_event);
endmodule // tsfd_top_assertions

bind tsfd_top tsfd_top_assertions u_chk (.clk(clk), .arst_n(arst_n),
  .mode(mode), .cfg_wr(cfg_wr), .cfg_chan(cfg_chan), .cfg_trim(cfg_trim),
  .chan_sel(chan_sel), .current_trim_control(current_trim_control),
  .conv_start(conv_start), .conv_valid(conv_valid),
  .sensor_pressed(sensor_pressed), .key_code(key_code),
  .key_event(key_event));

//--- tb/tsfd_top_bench.sv
// Self-checking bench for the touch filter and key decoder.
`timescale 1ns/1ps
module tsfd_top_bench
  import tsfd_pkg::*;
;
  localparam int unsigned SLOT = 150;
  localparam int unsigned SCAN = SLOT * NUM_CH;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  tsfd_mode_t mode = TSFD_MODE_WHEEL;
  logic cfg_wr = 1'b0;
  logic [CH_W-1:0] cfg_chan = 4'h0;
  logic [TRIM_W-1:0] cfg_trim = 8'h00;
  logic [RAW_W-1:0] cfg_trip = 10'h000;
  logic [NUM_CH-1:0][RAW_W-1:0] level = {NUM_CH{10'h200}};
  logic [CH_W-1:0] chan_sel;
  logic [TRIM_W-1:0] trim;
  logic conv_start;
  logic conv_valid;
  logic [RAW_W-1:0] conv_data;
  logic [NUM_CH-1:0] sensor_pressed;
  logic [KEY_W-1:0] key_code;
  logic key_event;
  logic [DBNC_W-1:0] dbnc = DBNC_DEFAULT;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_events = 0;
  tsfd_top #(.SLOT_CNT(SLOT)) uut (.clk(clk), .arst_n(arst_n),
    .mode(mode), .dbnc_count(dbnc), .cfg_wr(cfg_wr),
    .cfg_chan(cfg_chan), .cfg_trim(cfg_trim), .cfg_trip(cfg_trip),
    .chan_sel(chan_sel), .current_trim_control(trim),
    .conv_start(conv_start), .conv_valid(conv_valid),
    .conv_data(conv_data), .sensor_pressed(sensor_pressed),
    .key_code(key_code), .key_event(key_event));
  tsfd_fe_model u_fe (.clk(clk), .arst_n(arst_n), .conv_start(conv_start),
    .chan_sel(chan_sel), .level(level), .conv_valid(conv_valid),
    .conv_data(conv_data));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic give_verdict;
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Arguments are copied when the task is called, so the 1 ns wait does not move the sampling point.
  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    #1;
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic scans(input int n);
    repeat (n * SCAN) @(posedge clk);
  endtask
  // Levels change just after channel 15, so no sweep sees a mixed slot.
  task automatic sync_sweep;
    while (chan_sel !== 4'hf) @(negedge clk);
    while (chan_sel !== 4'h0) @(negedge clk);
    @(posedge clk);
  endtask
  task automatic set_mode(input tsfd_mode_t m);
    @(posedge clk);
    mode <= m;
    repeat (4) @(posedge clk);
  endtask
  // The baseline seeds once four scans have filled the history.
  task automatic t_ramp;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      cfg_wr <= 1'b1;
      cfg_chan <= i[3:0];
      cfg_trim <= 8'h10 + i[7:0];
      cfg_trip <= 10'h020;
    end
    @(posedge clk);
    cfg_wr <= 1'b0;
    while (conv_start !== 1'b1) @(negedge clk);
    check("trim", trim, 8'h10);
    check("chan", chan_sel, 4'h0);
    scans(6);
    check("pressed", sensor_pressed, 16'h0000);
    check("key", key_code, KEY_NONE);
    $display("test ramp done");
  endtask
  task automatic t_centre;
    int ev0;
    sync_sweep;
    for (int i = 0; i < 4; i++) level[i] <= 10'h1f8;
    scans(1);
    check("filtered", key_code, KEY_NONE);
    scans(3);
    check("centre", key_code, KEY_CENTRE);
    ev0 = n_events;
    set_mode(TSFD_MODE_PAIRED);
    check("quarters", key_code, KEY_NONE);
    check("event", 16'(n_events), 16'(ev0 + 1));
    set_mode(TSFD_MODE_WHEEL);
    $display("test centre done");
  endtask
  task automatic t_halves;
    sync_sweep;
    level[3:0] <= {10'h200, 10'h1ee, 10'h1ee, 10'h200};
    scans(4);
    check("diagonal", key_code, 5'h06);
    set_mode(TSFD_MODE_PAIRED);
    check("pair", key_code, 5'h08);
    set_mode(TSFD_MODE_WHEEL);
    $display("test halves done");
  endtask
  task automatic t_single;
    sync_sweep;
    level[3:0] <= {10'h1c0, 10'h200, 10'h200, 10'h200};
    scans(4);
    check("early", sensor_pressed, 16'h0000);
    scans(1);
    check("pressed", sensor_pressed, 16'h0008);
    check("single", key_code, 5'h04);
    set_mode(TSFD_MODE_PAIRED);
    check("paired single", key_code, 5'h04);
    set_mode(TSFD_MODE_MATRIX);
    check("row only", key_code, KEY_NONE);
    $display("test single done");
  endtask
  // A shorter debounce count flips the new presses one sweep earlier.
  task automatic t_matrix;
    sync_sweep;
    level[0] <= 10'h1d0;
    level[5] <= 10'h1c0;
    level[7] <= 10'h1d0;
    dbnc <= 3'h2;
    scans(3);
    check("debounce two", sensor_pressed, 16'h0008);
    scans(1);
    check("pressed", sensor_pressed, 16'h00a9);
    check("matrix", key_code, 5'h11);
    $display("test matrix done");
  endtask
  always @(posedge clk) begin
    if (key_event === 1'b1) n_events <= n_events + 1;
  end
  // About 27 sweeps of 2400 cycles are expected; the ceiling adds margin.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 72000) begin
      err_total++;
      $display("ERROR timeout expected finish seen hang");
      give_verdict;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    t_ramp;
    t_centre;
    t_halves;
    t_single;
    t_matrix;
    give_verdict;
  end
endmodule // tsfd_top_bench
